// >>> enhanced_unit_ctrl.sv
// enhanced capture/compare/pwm control: registers, pin steering, shutdown, interrupts
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
// Operation
// RULE1 - one 16-bit value register serves as capture, compare or pwm duty register.
// RULE2 - the value register is reached as a low byte and a high byte.
// RULE3 - up to four modulated outputs exist, each with software-selected polarity.
// RULE4 - bits 7:6 of mode control pick the pwm output mode and the pins that carry it.
// RULE5 - modulated outputs share port and parallel-slave pins and take them over when chosen.
// RULE6 - value, mode control, shutdown and delay registers are all readable and writable.
// RULE7 - pwm outputs shut down on selectable analog or digital fault events.
// RULE8 - reset clears mode control to zero, module off, single-output configuration.
// RULE9 - bits 3:0 of mode control choose the capture event in capture mode.
// RULE10 - dual and quad pwm override the parallel-slave control of shared pins.
// RULE11 - software clears the direction bit of each shared pin that the module uses.
// RULE12 - the special event trigger does not set the timer interrupt flags.
module capture_pwm_ctrl (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [capture_pwm_ctrl_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [15:0] capture_value_i,
  input wire logic capture_event_i,
  input wire logic compare_match_i,
  input wire logic [3:0] pwm_raw_i,
  input wire logic [1:0] fault_analog_i,
  input wire logic fault_digital_i,
  input wire logic [3:0] port_out_i,
  input wire logic [3:0] port_dir_in_i,
  input wire logic [3:0] parallel_slave_out_i,
  input wire logic [3:0] parallel_slave_oe_i,
  input wire logic parallel_slave_enable_i,
  output capture_pwm_ctrl_pkg::pin_group_t pins_o,
  output logic [15:0] value_o,
  output capture_pwm_ctrl_pkg::mode_control_t mode_control_o,
  output logic special_event_o,
  output logic module_event_flag_o,
  output logic irq_o
);
  import capture_pwm_ctrl_pkg::*;

  mode_control_t mode_control_r;
  logic [7:0] value_low_byte_r;
  logic [7:0] value_high_byte_r;
  logic [7:0] auto_shutdown_control_r;
  logic [7:0] deadband_delay_control_r;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_set;
  logic shutdown_active_r;
  logic fault_hit;
  logic [7:0] rdata_nxt;
  reg_req_t req;
  op_mode_t op_mode;
  pin_group_t pins_nxt;
  logic [3:0] pwm_pol;
  logic [3:0] pwm_used;

  function automatic op_mode_t decode_mode(input logic [3:0] m);
    if (m == MODE_OFF) begin
      decode_mode = OP_OFF;
    end else if (m[3:2] == PWM_MODE_TOP) begin
      decode_mode = OP_PWM;
    end else if (m[3] == 1'b1) begin
      decode_mode = OP_COMPARE;
    end else if (m[2] == 1'b1) begin
      decode_mode = OP_CAPTURE;
    end else begin
      decode_mode = OP_COMPARE;
    end
  endfunction

  function automatic logic hit(input reg_req_t r, input logic [ADDR_W-1:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  assign op_mode = decode_mode(mode_control_r.mode_select);

  // RULE8 mode control reset
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mode_control_r <= MODE_CONTROL_RST;
    end else if (hit(req, OFS_MODE_CONTROL)) begin
      mode_control_r <= req.wdata;
    end
  end

  // RULE1 shared value register
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      value_low_byte_r <= VALUE_RST;
      value_high_byte_r <= VALUE_RST;
    end else if (op_mode == OP_CAPTURE && capture_event_i) begin
      // RULE9 capture event latch
      value_low_byte_r <= capture_value_i[7:0];
      value_high_byte_r <= capture_value_i[15:8];
    end else begin
      // RULE2 byte halves
      if (hit(req, OFS_VALUE_LOW)) begin
        value_low_byte_r <= req.wdata;
      end
      if (hit(req, OFS_VALUE_HIGH)) begin
        value_high_byte_r <= req.wdata;
      end
    end
  end

  // RULE6 shutdown and delay registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      auto_shutdown_control_r <= SHUTDOWN_RST;
      deadband_delay_control_r <= DEADBAND_RST;
    end else begin
      if (hit(req, OFS_AUTO_SHUTDOWN)) begin
        auto_shutdown_control_r <= req.wdata;
      end
      if (hit(req, OFS_DEADBAND)) begin
        deadband_delay_control_r <= req.wdata;
      end
    end
  end

  // RULE7 fault selection: bit0 analog0, bit1 analog1, bit2 digital; bit7 sticky state
  assign fault_hit = (auto_shutdown_control_r[0] && fault_analog_i[0])
                   || (auto_shutdown_control_r[1] && fault_analog_i[1])
                   || (auto_shutdown_control_r[2] && fault_digital_i);

  // RULE7 shutdown latch, fault wins over software clear
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      shutdown_active_r <= 1'b0;
    end else if (fault_hit && op_mode == OP_PWM) begin
      shutdown_active_r <= 1'b1;
    end else if (hit(req, OFS_AUTO_SHUTDOWN) && !req.wdata[7]) begin
      shutdown_active_r <= 1'b0;
    end
  end

  // RULE12 special event only, no timer flag
  assign special_event_o = (op_mode == OP_COMPARE)
                         && (mode_control_r.mode_select == MODE_SPECIAL) && compare_match_i;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_CAPTURE] = (op_mode == OP_CAPTURE) && capture_event_i;
    irq_set[IRQ_COMPARE] = (op_mode == OP_COMPARE) && compare_match_i;
    irq_set[IRQ_SHUTDOWN] = fault_hit && (op_mode == OP_PWM) && !shutdown_active_r;
  end

  // sticky status, set beats write-one-clear
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_status_r <= '0;
    end else if (hit(req, OFS_IRQ_STATUS)) begin
      irq_status_r <= (irq_status_r & ~req.wdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status_r <= irq_status_r | irq_set;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_mask_r <= '0;
    end else if (hit(req, OFS_IRQ_MASK)) begin
      irq_mask_r <= req.wdata[IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_status_r & irq_mask_r);
  assign module_event_flag_o = |irq_status_r[IRQ_COMPARE:IRQ_CAPTURE];

  // RULE3 polarity per output pair: mode select bit 1 for A and C, bit 0 for B and D
  always_comb begin
    pwm_pol = {mode_control_r.mode_select[0], mode_control_r.mode_select[1],
               mode_control_r.mode_select[0], mode_control_r.mode_select[1]};
    // RULE4 output configuration decode
    case (mode_control_r.out_config)
      OCFG_SINGLE: pwm_used = 4'b0001;
      OCFG_HALF: pwm_used = 4'b0011;
      OCFG_FULL_FWD: pwm_used = 4'b1111;
      OCFG_FULL_REV: pwm_used = 4'b1111;
      default: pwm_used = 4'b0001;
    endcase
    if (op_mode != OP_PWM) begin
      pwm_used = 4'b0001;
    end
  end

  // RULE5 pin steering onto shared port / parallel-slave pins
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (parallel_slave_enable_i && !(op_mode == OP_PWM && pwm_used[i])) begin
        pins_nxt.data[i] = parallel_slave_out_i[i];
        pins_nxt.oe[i] = parallel_slave_oe_i[i];
      end else begin
        pins_nxt.data[i] = port_out_i[i];
        // RULE11 direction bit still gates the driver
        pins_nxt.oe[i] = !port_dir_in_i[i];
      end
    end
    if (op_mode == OP_PWM) begin
      for (int i = 0; i < 4; i++) begin
        // RULE10 pwm overrides parallel-slave control
        if (pwm_used[i]) begin
          pins_nxt.data[i] = shutdown_active_r ? 1'b0 : (pwm_raw_i[i] ^ pwm_pol[i]);
          pins_nxt.oe[i] = !port_dir_in_i[i];
        end
      end
    end else if (op_mode == OP_COMPARE) begin
      pins_nxt.data[PIN_A] = pwm_raw_i[PIN_A];
      pins_nxt.oe[PIN_A] = !port_dir_in_i[PIN_A];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pins_o <= '0;
    end else begin
      pins_o <= pins_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      value_o <= '0;
      mode_control_o <= MODE_CONTROL_RST;
    end else begin
      value_o <= {value_high_byte_r, value_low_byte_r};
      mode_control_o <= mode_control_r;
    end
  end

  // RULE6 read-back
  always_comb begin
    case (req.addr)
      OFS_MODE_CONTROL: rdata_nxt = mode_control_r;
      OFS_VALUE_LOW: rdata_nxt = value_low_byte_r;
      OFS_VALUE_HIGH: rdata_nxt = value_high_byte_r;
      OFS_AUTO_SHUTDOWN: rdata_nxt = {shutdown_active_r, auto_shutdown_control_r[6:0]};
      OFS_DEADBAND: rdata_nxt = deadband_delay_control_r;
      OFS_IRQ_STATUS: rdata_nxt = {5'h0_0, irq_status_r};
      OFS_IRQ_MASK: rdata_nxt = {5'h0_0, irq_mask_r};
      OFS_PIN_STATE: rdata_nxt = {pins_o.oe, pins_o.data};
      default: rdata_nxt = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= BYTE_ZERO;
    end else if (req.rd) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= BYTE_ZERO;
    end
  end

  a_mode_reset_clear: assert property (@(posedge sys_clk_i) // RULE8
    srst_i |=> (mode_control_r == MODE_CONTROL_RST)) else $error("mode control not cleared");
  a_value_low_write: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE2
    hit(req, OFS_VALUE_LOW) && !(op_mode == OP_CAPTURE && capture_event_i)
    |=> value_low_byte_r == $past(reg_wdata_i)) else $error("low byte write lost");
  a_capture_latch: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE9
    op_mode == OP_CAPTURE && capture_event_i
    |=> {value_high_byte_r, value_low_byte_r} == $past(capture_value_i))
    else $error("capture value not latched");
  a_value_out: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE1
    ##1 value_o == $past({value_high_byte_r, value_low_byte_r})) else $error("value out wrong");
  a_read_data: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE6
    reg_rd_i && reg_addr_i == OFS_DEADBAND |=> reg_rdata_o == $past(deadband_delay_control_r))
    else $error("read data wrong");
  a_shutdown_forces: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE7
    shutdown_active_r && op_mode == OP_PWM |=> pins_o.data[PIN_A] == 1'b0)
    else $error("shutdown not forcing output");
  a_half_pins_used: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE4
    op_mode == OP_PWM && mode_control_r.out_config == OCFG_HALF |-> pwm_used == 4'b0011)
    else $error("half bridge pin set wrong");
  a_pwm_pin_override: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE10
    op_mode == OP_PWM && pwm_used[PIN_D] && !shutdown_active_r
    |=> pins_o.data[PIN_D] == $past(pwm_raw_i[PIN_D] ^ pwm_pol[PIN_D]))
    else $error("pwm did not override shared pin");
  a_event_not_lost: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE12
    irq_set[IRQ_COMPARE] |=> irq_status_r[IRQ_COMPARE]) else $error("compare flag lost");
  c_capture: cover property (@(posedge sys_clk_i) op_mode == OP_CAPTURE && capture_event_i);
  c_quad_pwm: cover property (@(posedge sys_clk_i) op_mode == OP_PWM && pwm_used == 4'b1111);
  c_shutdown: cover property (@(posedge sys_clk_i) $rose(shutdown_active_r));
  c_special: cover property (@(posedge sys_clk_i) special_event_o);
endmodule

// >>> enhanced_unit_ctrl_pkg.sv
// register map, field layout and types for the enhanced capture/compare/pwm control block
package capture_pwm_ctrl_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_MODE_CONTROL = 4'h0;
  localparam logic [3:0] OFS_VALUE_LOW = 4'h1;
  localparam logic [3:0] OFS_VALUE_HIGH = 4'h2;
  localparam logic [3:0] OFS_AUTO_SHUTDOWN = 4'h3;
  localparam logic [3:0] OFS_DEADBAND = 4'h4;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h5;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h6;
  localparam logic [3:0] OFS_PIN_STATE = 4'h7;
  localparam logic [7:0] MODE_CONTROL_RST = 8'h00;
  localparam logic [7:0] SHUTDOWN_RST = 8'h00;
  localparam logic [7:0] DEADBAND_RST = 8'h00;
  localparam logic [7:0] VALUE_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] OCFG_SINGLE = 2'h0;
  localparam logic [1:0] OCFG_FULL_FWD = 2'h1;
  localparam logic [1:0] OCFG_HALF = 2'h2;
  localparam logic [1:0] OCFG_FULL_REV = 2'h3;
  localparam logic [1:0] PWM_MODE_TOP = 2'h3;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;
  localparam int IRQ_W = 3;
  localparam int IRQ_CAPTURE = 0;
  localparam int IRQ_COMPARE = 1;
  localparam int IRQ_SHUTDOWN = 2;
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_D = 3;

  typedef struct packed {
    logic [1:0] out_config;
    logic [1:0] duty_lsb;
    logic [3:0] mode_select;
  } mode_control_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [3:0] data;
    logic [3:0] oe;
  } pin_group_t;

  typedef enum logic [1:0] {
    OP_OFF = 2'b00,
    OP_CAPTURE = 2'b01,
    OP_COMPARE = 2'b10,
    OP_PWM = 2'b11
  } op_mode_t;
endpackage

// >>> bridge_model.sv
// behavioural model of the external bridge gate drivers
`timescale 1ns/1ps
module bridge_model (
  input wire logic sys_clk_i,
  input wire capture_pwm_ctrl_pkg::pin_group_t pins_i,
  output logic [3:0] gate_o
);
  import capture_pwm_ctrl_pkg::*;
  logic [3:0] last_r = 4'h0;
  always @(posedge sys_clk_i) begin
    last_r <= gate_o;
  end
  // an undriven gate input floats away from its last level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gate_o[i] = pins_i.oe[i] ? pins_i.data[i] : ~last_r[i];
    end
  end
endmodule

// >>> enhanced_capture_compare_pwm_control_bench.sv
// self-checking bench for the capture/compare/pwm control block
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module enhanced_capture_compare_pwm_control_bench;
  import capture_pwm_ctrl_pkg::*;
  typedef struct packed {
    logic [7:0] mode;
    logic [3:0] raw;
    logic [3:0] used;
    logic [3:0] exp;
  } row_t;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [15:0] cap_val = 16'h0000;
  logic cap_ev = 1'b0;
  logic cmp_match = 1'b0;
  logic [3:0] raw = 4'h0;
  logic [1:0] f_an = 2'h0;
  logic [3:0] port_dir = 4'h0;
  pin_group_t pins;
  logic [15:0] value;
  mode_control_t mc;
  logic special;
  logic evt_flag;
  logic irq;
  logic irq_a;
  logic [3:0] gate;
  int failures = 0;
  int comparisons = 0;
  row_t rows [9] = '{'{8'h0c, 4'h5, 4'h1, 4'h1}, '{8'h0e, 4'h5, 4'h1, 4'h0},
    '{8'h0d, 4'ha, 4'h1, 4'h0}, '{8'h8c, 4'ha, 4'h3, 4'h2}, '{8'h8f, 4'h5, 4'h3, 4'h2},
    '{8'h4c, 4'h5, 4'hf, 4'h5}, '{8'hcd, 4'h5, 4'hf, 4'hf}, '{8'h4e, 4'h5, 4'hf, 4'h0},
    '{8'h0b, 4'h5, 4'h1, 4'h1}};

  capture_pwm_ctrl capture_pwm_ctrl_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .capture_value_i(cap_val), .capture_event_i(cap_ev), .compare_match_i(cmp_match),
    .pwm_raw_i(raw), .fault_analog_i(f_an), .fault_digital_i(1'b0), .port_out_i(4'h0),
    .port_dir_in_i(port_dir), .parallel_slave_out_i(4'hf), .parallel_slave_oe_i(4'hf),
    .parallel_slave_enable_i(1'b1),
    .pins_o(pins), .value_o(value), .mode_control_o(mc), .special_event_o(special),
    .module_event_flag_o(evt_flag), .irq_o(irq));
  bridge_model bridge_model_inst (.sys_clk_i(sys_clk_i), .pins_i(pins), .gate_o(gate));

  always #2.5 sys_clk_i = ~sys_clk_i;

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask

  task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1;
    `CHK(rdata, d)
  endtask

  task automatic settle();
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic final_report();
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      read_chk(4'(i), 8'h00);
    end
    `CHK(mc, MODE_CONTROL_RST)
    reg_write(OFS_VALUE_LOW, 8'h34);
    reg_write(OFS_VALUE_HIGH, 8'h12);
    settle();
    `CHK(value, 16'h1234)
    read_chk(OFS_VALUE_LOW, 8'h34);
    read_chk(OFS_VALUE_HIGH, 8'h12);
    reg_write(4'hf, 8'hff);
    read_chk(4'hf, 8'h00);
    reg_write(OFS_DEADBAND, 8'ha5);
    read_chk(OFS_DEADBAND, 8'ha5);
    reg_write(OFS_AUTO_SHUTDOWN, 8'h06);
    read_chk(OFS_AUTO_SHUTDOWN, 8'h06);
    for (int i = 0; i < 9; i++) begin
      @(posedge sys_clk_i);
      raw <= rows[i].raw;
      reg_write(OFS_MODE_CONTROL, rows[i].mode);
      settle();
      read_chk(OFS_MODE_CONTROL, rows[i].mode);
      `CHK(mc, rows[i].mode)
      `CHK(gate & rows[i].used, rows[i].exp)
      `CHK(pins.oe & rows[i].used, rows[i].used)
    end
    reg_write(OFS_IRQ_MASK, 8'h07);
    reg_write(OFS_MODE_CONTROL, 8'h04);
    @(posedge sys_clk_i);
    cap_val <= 16'hbeef;
    cap_ev <= 1'b1;
    @(posedge sys_clk_i);
    cap_ev <= 1'b0;
    settle();
    `CHK(value, 16'hbeef)
    `CHK(evt_flag, 1'b1)
    irq_a = irq;
    reg_write(OFS_IRQ_MASK, 8'h00);
    settle();
    `CHK(irq_a ^ irq, 1'b1)
    reg_write(OFS_IRQ_STATUS, 8'h07);
    read_chk(OFS_IRQ_STATUS, 8'h00);
    reg_write(OFS_MODE_CONTROL, 8'(MODE_SPECIAL));
    @(posedge sys_clk_i);
    cmp_match <= 1'b1;
    #1;
    `CHK(special, 1'b1)
    @(posedge sys_clk_i);
    cmp_match <= 1'b0;
    #1;
    `CHK(special, 1'b0)
    reg_write(OFS_MODE_CONTROL, 8'h4c);
    reg_write(OFS_AUTO_SHUTDOWN, 8'h01);
    @(posedge sys_clk_i);
    raw <= 4'hf;
    f_an <= 2'h1;
    settle();
    `CHK(gate, 4'h0)
    read_chk(OFS_AUTO_SHUTDOWN, 8'h81);
    @(posedge sys_clk_i);
    f_an <= 2'h0;
    reg_write(OFS_AUTO_SHUTDOWN, 8'h01);
    settle();
    `CHK(gate, 4'hf)
    @(posedge sys_clk_i);
    raw <= 4'h0;
    settle();
    `CHK(gate, 4'h0)
    final_report();
  end
endmodule
